// ==== src/pld_pkg.sv ====
/*
 * Shared constants and carriers for the programmable sum-of-products array
 * and its output cells: array geometry, register offsets, field positions,
 * reset values and the packed configuration and pin bundles.
 * Assumes a single system clock and Avalon-MM register access.
 */
package pld_pkg;

    // Array geometry
    localparam int NUM_CELLS = 8;
    localparam int NUM_DEDICATED = 8;
    localparam int NUM_ARRAY_IN = NUM_DEDICATED + 2 + NUM_CELLS;
    localparam int NUM_COLS = 2 * NUM_ARRAY_IN;
    localparam int SUM_TERMS = 8;
    localparam int TERMS_PER_CELL = SUM_TERMS + 1;
    localparam int NUM_ROWS = NUM_CELLS * TERMS_PER_CELL;
    localparam int FUSE_ADDR_W = 7;
    localparam int FUSE_HI_W = NUM_COLS - 32;
    localparam int CFG_BITS = 4;

    // Array input positions: dedicated pins, clock pin, enable pin, feedback
    localparam int IN_CLK_IDX = NUM_DEDICATED;
    localparam int IN_OE_IDX = NUM_DEDICATED + 1;
    localparam int IN_FB_BASE = NUM_DEDICATED + 2;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_FUSE_ADDR = 8'h08;
    localparam logic [7:0] OFS_FUSE_LO = 8'h0c;
    localparam logic [7:0] OFS_FUSE_HI = 8'h10;
    localparam logic [7:0] OFS_CONFIG = 8'h14;
    localparam logic [7:0] OFS_PRELOAD = 8'h18;

    // Field positions
    localparam int CTRL_LOCK_POS = 0;
    localparam int CTRL_ERASE_POS = 1;
    localparam int STAT_LOCK_POS = 0;
    localparam int STAT_Q_POS = 8;
    localparam int STAT_OE_POS = 16;
    localparam int STAT_OUT_POS = 24;

    // Reset and virgin values
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [NUM_COLS-1:0] FUSE_ROW_RESET = {NUM_COLS{1'b1}};
    localparam logic Q_RESET = 1'b0;

    // Bus answer timing: cycles of waitrequest before the answer
    localparam logic [1:0] ACK_WAIT = 2'h2;

    typedef struct packed {
        logic feedback_select_bit;
        logic enable_source_bit;
        logic mode_select_bit;
        logic polarity_select_bit;
    } cell_cfg_type;

    typedef struct packed {
        logic [NUM_CELLS-1:0] io;
        logic oe_n;
        logic clk;
        logic [NUM_DEDICATED-1:0] ded;
    } pin_in_type;

endpackage

// ==== src/fuse_store.sv ====
/*
 * Connection memory of the AND array: one row per product term, one bit per
 * array column, all rows visible in parallel plus a registered read port.
 * Assumes the caller blocks writes when the pattern is secured.
 */
module fuse_store #(
    parameter int ROWS = pld_pkg::NUM_ROWS,
    parameter int WIDTH = pld_pkg::NUM_COLS,
    parameter int AW = pld_pkg::FUSE_ADDR_W
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_erase,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata,
    output logic [ROWS*WIDTH-1:0] o_all
);
    import pld_pkg::*;

    logic [WIDTH-1:0] mem_r [ROWS];
    logic [WIDTH-1:0] rdata_r;

    // Refused at elaboration: flat output and row decode assume this shape
    if (ROWS < 1 || ROWS > (1 << AW) || WIDTH != NUM_COLS) begin : g_bad_geometry
        $error("fuse_store: geometry not servable");
    end

    // Virgin state: every term joined to true and complement of each input
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int r = 0; r < ROWS; r++) begin
                mem_r[r] <= FUSE_ROW_RESET;
            end
        end else if (i_erase) begin
            for (int r = 0; r < ROWS; r++) begin
                mem_r[r] <= FUSE_ROW_RESET;
            end
        end else if (i_we && 32'(i_waddr) < ROWS) begin
            mem_r[i_waddr] <= i_wdata;
        end
    end

    // Out-of-range rows read as zero
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= (32'(i_raddr) < ROWS) ? mem_r[i_raddr] : '0;
        end
    end

    assign o_rdata = rdata_r;

    for (genvar r = 0; r < ROWS; r++) begin : g_flat
        assign o_all[r*WIDTH +: WIDTH] = mem_r[r];
    end

endmodule

// ==== src/output_cell.sv ====
/*
 * One configurable output cell: storage flip-flop, mode, polarity,
 * enable source and feedback selection.
 * Assumes i_tick is a one-cycle pulse on a rising edge of the array clock pin
 * and that all pin levels arrive already synchronised.
 */
module output_cell (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire pld_pkg::cell_cfg_type i_cfg,
    input wire logic i_sum,
    input wire logic i_oe_term,
    input wire logic i_oe_n,
    input wire logic i_pin_in,
    input wire logic i_tick,
    input wire logic i_preload,
    input wire logic i_preload_val,
    output logic o_pin_out,
    output logic o_pin_oe,
    output logic o_q,
    output logic o_feedback
);
    import pld_pkg::*;

    logic q_r;
    logic sel_value;

    // Register comes up low; preload needs no pin clock edge
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            q_r <= Q_RESET;
        end else if (i_preload) begin
            q_r <= i_preload_val;
        end else if (i_tick) begin
            q_r <= i_sum;
        end
    end

    // Mode, polarity, enable and feedback selection
    assign sel_value = i_cfg.mode_select_bit ? i_sum : q_r;
    assign o_pin_out = i_cfg.polarity_select_bit ? sel_value : ~sel_value;
    assign o_pin_oe = i_cfg.enable_source_bit ? i_oe_term : ~i_oe_n;
    assign o_feedback = i_cfg.feedback_select_bit ? i_pin_in : q_r;
    assign o_q = q_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_tick_captures_sum: assert property (
        i_tick && !i_preload |=> q_r == $past(i_sum))
        else $error("register missed the pin clock edge");
    a_virgin_cell_default: assert property (
        i_cfg == '0 |-> o_pin_out == !q_r && o_pin_oe == !i_oe_n)
        else $error("unprogrammed cell not registered active low pin enabled");
    a_feedback_register: assert property (
        !i_cfg.feedback_select_bit |-> o_feedback == q_r)
        else $error("feedback not taken from register");
    a_comb_follows_sum: assert property (
        i_cfg.mode_select_bit && i_cfg.polarity_select_bit |-> o_pin_out == i_sum)
        else $error("combinatorial output does not follow sum");
    a_powerup_low: assert property (
        $fell(i_reset) |-> !q_r)
        else $error("register not low after reset");

endmodule

// ==== src/pld_array.sv ====
/*
 * Programmable AND-OR array with eight configurable output cells, pin
 * synchronisers and an Avalon-MM register slave for programming the
 * connection pattern, the cell configuration, preload and security.
 * Assumes pins are asynchronous to i_clk; the array clock pin is sampled
 * and its rising edge becomes a one-cycle enable.
 */
// Functional notes
// - Every output function is an OR of AND terms from one array.
// - Virgin terms join true and complement; programming keeps true, complement or neither.
// - Each output ORs eight terms, plus one term of its own for enable.
// - Eighteen array inputs and eight outputs; output pins also feed back.
// - Four configuration bits per cell, sixteen configurations, set per cell.
// - An unprogrammed cell is registered, active low, enabled by the pin.
// - Mode bit picks register output or the direct sum term.
// - Output pins are two-way; disabled, they serve only as array inputs.
// - Register output is fed back to the array in both modes.
// - All cell registers clock from one shared clock pin.
// - Registers start with true output low after power-up.
// - Enable-source bit picks enable term or the active-low enable pin.
// - Polarity bit picks active high or active low output.
// - Test preload forces the registers to any chosen pattern.
// - Once secured, the programmed pattern cannot be read back.
// - Feedback bit: zero takes register output, one takes the pin.
// - Polarity one high, mode one combinatorial, enable one product term.
// - All configuration bits read zero when virgin.
module pld_array (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire pld_pkg::pin_in_type i_pins,
    output logic [pld_pkg::NUM_CELLS-1:0] o_io_out,
    output logic [pld_pkg::NUM_CELLS-1:0] o_io_oe
);
    import pld_pkg::*;

    localparam int PIN_W = $bits(pin_in_type);

    // Refused at elaboration: geometries the register map cannot hold
    if (NUM_CELLS * CFG_BITS > 32 || NUM_CELLS > 8
        || FUSE_HI_W < 1 || FUSE_HI_W > 32) begin : g_bad_map
        $error("pld_array: geometry does not fit the register map");
    end
    if (NUM_ROWS > (1 << FUSE_ADDR_W)) begin : g_bad_addr
        $error("pld_array: fuse address too narrow");
    end

    // Word decode on a byte address
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = (addr[7:2] == ofs[7:2]);
    endfunction

    // Byte-lane merge for partial writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
        lane_merge = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                lane_merge[8*b +: 8] = new_v[8*b +: 8];
            end
        end
    endfunction

    logic [PIN_W-1:0] pin_meta_r;
    logic [PIN_W-1:0] pin_sync_r;
    logic pin_clk_prev_r;
    pin_in_type pins_s;
    logic tick;

    logic [1:0] wait_cnt_r;
    logic [31:0] readdata_r;
    logic [31:0] cfg_r;
    logic lock_r;
    logic [FUSE_ADDR_W-1:0] fuse_addr_r;
    logic [FUSE_ADDR_W-1:0] fuse_addr_nxt;
    logic [FUSE_HI_W-1:0] fuse_hi_r;

    logic req;
    logic write_go;
    logic erase_go;
    logic lock_go;
    logic preload_go;
    logic fuse_we;
    logic [NUM_CELLS-1:0] preload_val;
    logic [31:0] read_mux;

    logic [NUM_COLS-1:0] fuse_rdata;
    logic [NUM_ROWS*NUM_COLS-1:0] fuse_flat;
    logic [NUM_ARRAY_IN-1:0] array_in;
    logic [NUM_COLS-1:0] literals;
    logic [NUM_ROWS-1:0] terms;
    logic [NUM_CELLS-1:0] feedback;
    logic [NUM_CELLS-1:0] q_vec;

    // Two-stage pin synchroniser; only the second stage is read
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            pin_clk_prev_r <= 1'b0;
        end else begin
            pin_meta_r <= i_pins;
            pin_sync_r <= pin_meta_r;
            pin_clk_prev_r <= pins_s.clk;
        end
    end

    assign pins_s = pin_in_type'(pin_sync_r);
    // One shared clock pin edge drives every cell
    assign tick = pins_s.clk && !pin_clk_prev_r;

    // Array inputs: dedicated pins, clock pin, enable pin, cell feedback
    assign array_in[NUM_DEDICATED-1:0] = pins_s.ded;
    assign array_in[IN_CLK_IDX] = pins_s.clk;
    assign array_in[IN_OE_IDX] = pins_s.oe_n;
    assign array_in[IN_FB_BASE +: NUM_CELLS] = feedback;

    // True and complement column per input
    for (genvar i = 0; i < NUM_ARRAY_IN; i++) begin : g_lit
        assign literals[2*i] = array_in[i];
        assign literals[2*i+1] = ~array_in[i];
    end

    // A joined column takes part in the term; a cleared one is ignored
    for (genvar r = 0; r < NUM_ROWS; r++) begin : g_term
        assign terms[r] = &(literals | ~fuse_flat[r*NUM_COLS +: NUM_COLS]);
    end

    // Cells: eight OR-ed terms plus a dedicated enable term each
    for (genvar k = 0; k < NUM_CELLS; k++) begin : g_cell
        output_cell u_cell (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_cfg(cell_cfg_type'(cfg_r[k*CFG_BITS +: CFG_BITS])),
            .i_sum(|terms[k*TERMS_PER_CELL +: SUM_TERMS]),
            .i_oe_term(terms[k*TERMS_PER_CELL + SUM_TERMS]),
            .i_oe_n(pins_s.oe_n),
            .i_pin_in(pins_s.io[k]),
            .i_tick(tick),
            .i_preload(preload_go),
            .i_preload_val(preload_val[k]),
            .o_pin_out(o_io_out[k]),
            .o_pin_oe(o_io_oe[k]),
            .o_q(q_vec[k]),
            .o_feedback(feedback[k])
        );
    end

    fuse_store u_fuses (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_erase(erase_go),
        .i_we(fuse_we),
        .i_waddr(fuse_addr_r),
        .i_wdata({fuse_hi_r, i_avs_writedata}),
        .i_raddr(fuse_addr_nxt),
        .o_rdata(fuse_rdata),
        .o_all(fuse_flat)
    );

    // Bus handshake: fixed wait so the fuse read port settles first
    assign req = i_avs_read || i_avs_write;
    assign o_avs_waitrequest = req && (wait_cnt_r != ACK_WAIT);
    assign write_go = i_avs_write && (wait_cnt_r == ACK_WAIT);
    assign o_avs_readdata = readdata_r;

    // Write strobes; a secured pattern cannot be altered short of erase or reset
    assign erase_go = write_go && reg_hit(i_avs_address, OFS_CTRL)
                      && i_avs_byteenable[0] && i_avs_writedata[CTRL_ERASE_POS];
    assign lock_go = write_go && reg_hit(i_avs_address, OFS_CTRL)
                     && i_avs_byteenable[0] && i_avs_writedata[CTRL_LOCK_POS];
    assign preload_go = write_go && reg_hit(i_avs_address, OFS_PRELOAD)
                        && i_avs_byteenable[0];
    assign preload_val = i_avs_writedata[NUM_CELLS-1:0];
    assign fuse_we = write_go && reg_hit(i_avs_address, OFS_FUSE_LO) && !lock_r;
    assign fuse_addr_nxt = (write_go && reg_hit(i_avs_address, OFS_FUSE_ADDR)
                            && i_avs_byteenable[0])
                           ? i_avs_writedata[FUSE_ADDR_W-1:0] : fuse_addr_r;

    // Read selection; pattern registers read zero while secured
    assign read_mux =
        reg_hit(i_avs_address, OFS_CTRL) ? {31'h0000_0000, lock_r} :
        reg_hit(i_avs_address, OFS_STATUS) ?
            (32'(o_io_out) << STAT_OUT_POS) | (32'(o_io_oe) << STAT_OE_POS)
            | (32'(q_vec) << STAT_Q_POS) | (32'(lock_r) << STAT_LOCK_POS) :
        reg_hit(i_avs_address, OFS_FUSE_ADDR) ? 32'(fuse_addr_r) :
        reg_hit(i_avs_address, OFS_FUSE_LO) ?
            (lock_r ? 32'h0000_0000 : fuse_rdata[31:0]) :
        reg_hit(i_avs_address, OFS_FUSE_HI) ?
            (lock_r ? 32'h0000_0000 : 32'(fuse_rdata[NUM_COLS-1:32])) :
        reg_hit(i_avs_address, OFS_CONFIG) ? (lock_r ? 32'h0000_0000 : cfg_r) :
        reg_hit(i_avs_address, OFS_PRELOAD) ? 32'(q_vec) :
        32'h0000_0000;

    // Wait counter and read capture one edge before the answer
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wait_cnt_r <= 2'h0;
            readdata_r <= 32'h0000_0000;
        end else begin
            wait_cnt_r <= o_avs_waitrequest ? wait_cnt_r + 2'h1 : 2'h0;
            if (i_avs_read && wait_cnt_r == ACK_WAIT - 2'h1) begin
                readdata_r <= read_mux;
            end
        end
    end

    // Security latch: only an erase or reset clears it, and erase wins
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            lock_r <= 1'b0;
        end else if (erase_go) begin
            lock_r <= 1'b0;
        end else if (lock_go) begin
            lock_r <= 1'b1;
        end
    end

    // Configuration and fuse staging registers
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cfg_r <= CFG_RESET;
            fuse_addr_r <= '0;
            fuse_hi_r <= '0;
        end else if (erase_go) begin
            cfg_r <= CFG_RESET;
            fuse_addr_r <= '0;
            fuse_hi_r <= '0;
        end else begin
            fuse_addr_r <= fuse_addr_nxt;
            if (write_go && !lock_r && reg_hit(i_avs_address, OFS_CONFIG)) begin
                cfg_r <= lane_merge(cfg_r, i_avs_writedata, i_avs_byteenable);
            end
            if (write_go && !lock_r && reg_hit(i_avs_address, OFS_FUSE_HI)
                && i_avs_byteenable[0]) begin
                fuse_hi_r <= i_avs_writedata[FUSE_HI_W-1:0];
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_req_start;
        req && wait_cnt_r == 2'h0;
    endsequence
    sequence s_req_held;
        s_req_start ##1 req ##1 req;
    endsequence

    a_bus_answer_time: assert property (
        s_req_held |-> !o_avs_waitrequest)
        else $error("bus answer not in third cycle");
    a_lock_hides_pattern: assert property (
        i_avs_read && !o_avs_waitrequest && lock_r && $past(lock_r)
        && reg_hit(i_avs_address, OFS_CONFIG) |-> o_avs_readdata == 32'h0000_0000)
        else $error("secured configuration was readable");
    a_lock_sticky: assert property (
        lock_r && !erase_go |=> lock_r)
        else $error("security cleared without erase");
    a_erase_virgin: assert property (
        erase_go |=> cfg_r == CFG_RESET && !lock_r)
        else $error("erase did not restore virgin configuration");
    a_preload_pattern: assert property (
        preload_go |=> q_vec == $past(preload_val))
        else $error("preload pattern not loaded");
    a_virgin_term_low: assert property (
        fuse_flat[NUM_COLS-1:0] == FUSE_ROW_RESET |-> !terms[0])
        else $error("virgin term not low");

    // Read answer of the preload register; a tick in between would move it
    sequence s_preload_read;
        i_avs_read && !o_avs_waitrequest
        && reg_hit(i_avs_address, OFS_PRELOAD) && $stable(q_vec);
    endsequence

    a_preload_readback: assert property (
        s_preload_read |-> o_avs_readdata == 32'(q_vec))
        else $error("preload register read back wrong");
    a_tick_single_pulse: assert property (
        tick |=> !tick)
        else $error("pin clock edge lasted more than one cycle");
    a_write_single_take: assert property (
        write_go |=> !write_go)
        else $error("one write taken twice");
    a_secured_cfg_frozen: assert property (
        write_go && lock_r && reg_hit(i_avs_address, OFS_CONFIG) |=> cfg_r == $past(cfg_r))
        else $error("secured configuration was altered");
    a_erase_fuses_virgin: assert property (
        erase_go |=> fuse_flat == {NUM_ROWS{FUSE_ROW_RESET}})
        else $error("erase left a programmed connection");

endmodule

// ==== dv/board_model.sv ====
/*
 * Board-side model of the logic around the array: dedicated inputs, the
 * array clock pin, the active-low enable pin and the eight shared I/O wires.
 * Assumes the bench never drives a wire while the device drives it.
 */
module board_model (
    input wire logic [7:0] i_ded,
    input wire logic i_clk_pin,
    input wire logic i_oe_n_pin,
    input wire logic [7:0] i_drive_val,
    input wire logic [7:0] i_drive_en,
    input wire logic [pld_pkg::NUM_CELLS-1:0] i_io_out,
    input wire logic [pld_pkg::NUM_CELLS-1:0] i_io_oe,
    output pld_pkg::pin_in_type o_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    import pld_pkg::*;
    logic [NUM_CELLS-1:0] io_wire;

    // Device drive wins; a wire nobody drives is tied to ground, never left floating
    assign io_wire = (i_io_oe & i_io_out) | (~i_io_oe & i_drive_en & i_drive_val);
    assign o_pins = '{io: io_wire, oe_n: i_oe_n_pin, clk: i_clk_pin, ded: i_ded};
endmodule

// ==== dv/test_programmable_output_macrocell.sv ====
/*
 * Self-checking bench for the array: bus tasks program terms and cell
 * settings, pins are moved through the board model, results read back.
 * Assumes two wait states per access and two-flop pin synchronisers.
 */
module test_programmable_output_macrocell;
    timeunit 1ns;
    timeprecision 1ns;
    import pld_pkg::*;
    localparam int CYCLE_LIMIT = 3000;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [7:0] ded = 8'h00;
    logic [7:0] drive_val = 8'h00;
    logic [7:0] drive_en = 8'h00;
    logic clk_pin = 1'b0;
    logic oe_n_pin = 1'b0;
    pin_in_type pins;
    logic [7:0] io_out;
    logic [7:0] io_oe;
    logic [31:0] rd;
    logic [31:0] cfg_set [2] = '{32'h7654_3210, 32'hfedc_ba98};
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;

    // Free-running system clock, 100 ns period
    always #50 clk = ~clk;

    pld_array pld_array_inst (.i_clk(clk), .i_reset(reset), .i_avs_address(address),
        .i_avs_read(read), .i_avs_write(write), .i_avs_writedata(writedata),
        .i_avs_byteenable(byteenable), .o_avs_readdata(readdata),
        .o_avs_waitrequest(waitrequest), .i_pins(pins), .o_io_out(io_out), .o_io_oe(io_oe));
    board_model board_model_inst (.i_ded(ded), .i_clk_pin(clk_pin), .i_oe_n_pin(oe_n_pin),
        .i_drive_val(drive_val), .i_drive_en(drive_en), .i_io_out(io_out),
        .i_io_oe(io_oe), .o_pins(pins));

    task automatic results();
        $display("mismatches %0d, comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One access; held until waitrequest is seen low, data taken at that edge
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
        @(posedge clk);
        address <= adr;
        writedata <= wd;
        byteenable <= 4'hf;
        read <= !wr;
        write <= wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        bus(1'b1, adr, wd);
    endtask

    task automatic rd_check(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0000_0000);
        check(rd, exp);
    endtask

    // Address, upper bits, then the low word that commits the row
    task automatic prog_row(input logic [FUSE_ADDR_W-1:0] row, input logic [NUM_COLS-1:0] v);
        wr(OFS_FUSE_ADDR, {{(32-FUSE_ADDR_W){1'b0}}, row});
        wr(OFS_FUSE_HI, {{(32-FUSE_HI_W){1'b0}}, v[NUM_COLS-1:32]});
        wr(OFS_FUSE_LO, v[31:0]);
    endtask

    // Pins pass two sync flops plus edge detect; six cycles covers it
    task automatic pins_set(input logic [7:0] d, input logic oe_n, input logic [7:0] dv,
                            input logic [7:0] de);
        @(posedge clk);
        ded <= d;
        oe_n_pin <= oe_n;
        drive_val <= dv;
        drive_en <= de;
        repeat (6) @(posedge clk);
    endtask

    task automatic pin_clock();
        @(posedge clk);
        clk_pin <= 1'b1;
        repeat (4) @(posedge clk);
        clk_pin <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            bad_count++;
            results();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        // Virgin cells: registered, active low of Q=0, enabled by the low pin
        rd_check(OFS_STATUS, 32'hffff_0000);
        rd_check(OFS_CONFIG, CFG_RESET);
        rd_check(8'h1c, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            wr(OFS_CONFIG, cfg_set[i]);
            rd_check(OFS_CONFIG, cfg_set[i]);
        end
        wr(OFS_CONFIG, 32'h0000_0000);
        // Term 0 of cell 0 keeps only the true column of dedicated input 0
        prog_row(7'h00, 36'h0_0000_0001);
        rd_check(OFS_FUSE_LO, 32'h0000_0001);
        wr(OFS_FUSE_ADDR, 32'h0000_0001);
        rd_check(OFS_FUSE_HI, 32'h0000_000f);
        prog_row(7'h08, 36'h0_0000_0000);
        prog_row(7'h09, 36'h0_0010_0000);
        prog_row(7'h11, 36'h0_0000_0000);
        // Combinatorial, active high, enable term that is always true
        wr(OFS_CONFIG, 32'h0000_0077);
        pins_set(8'h01, 1'b0, 8'h00, 8'h00);
        check({31'h0, io_out[0]}, 32'h1);
        check({31'h0, io_oe[0]}, 32'h1);
        pins_set(8'h00, 1'b0, 8'h00, 8'h00);
        check({31'h0, io_out[0]}, 32'h0);
        wr(OFS_CONFIG, 32'h0000_0076);
        repeat (2) @(posedge clk);
        check({31'h0, io_out[0]}, 32'h1);
        // Enable term now follows dedicated input 1
        prog_row(7'h08, 36'h0_0000_0004);
        pins_set(8'h00, 1'b0, 8'h00, 8'h00);
        check({31'h0, io_oe[0]}, 32'h0);
        pins_set(8'h02, 1'b0, 8'h00, 8'h00);
        check({31'h0, io_oe[0]}, 32'h1);
        wr(OFS_CONFIG, 32'h0000_0072);
        pins_set(8'h02, 1'b1, 8'h00, 8'h00);
        check({31'h0, io_oe[0]}, 32'h0);
        // Registered cell 0; cell 1 shows the fed-back register of cell 0
        wr(OFS_CONFIG, 32'h0000_0071);
        pins_set(8'h01, 1'b0, 8'h00, 8'h00);
        pin_clock();
        check({31'h0, io_out[0]}, 32'h1);
        check({31'h0, io_out[1]}, 32'h1);
        rd_check(OFS_PRELOAD, 32'h0000_0001);
        // Pin feedback: cell 0 released, board drives its wire against Q
        wr(OFS_CONFIG, 32'h0000_0079);
        pins_set(8'h01, 1'b1, 8'h00, 8'h01);
        check({31'h0, io_out[1]}, 32'h0);
        pins_set(8'h01, 1'b1, 8'h01, 8'h01);
        check({31'h0, io_out[1]}, 32'h1);
        pins_set(8'h00, 1'b0, 8'h00, 8'h00);
        // Preload without a pin clock, then one clock from the loaded state
        wr(OFS_CONFIG, 32'h0000_0071);
        wr(OFS_PRELOAD, 32'h0000_00a5);
        rd_check(OFS_PRELOAD, 32'h0000_00a5);
        pin_clock();
        rd_check(OFS_PRELOAD, 32'h0000_0002);
        // Secured pattern hides fuses and settings until erased
        wr(OFS_CTRL, 32'h0000_0001);
        rd_check(OFS_CTRL, 32'h0000_0001);
        rd_check(OFS_CONFIG, 32'h0000_0000);
        // Refused write: cell 1 would turn registered and show its high Q
        wr(OFS_CONFIG, 32'h0000_0011);
        repeat (2) @(posedge clk);
        check({31'h0, io_out[1]}, 32'h0);
        wr(OFS_FUSE_ADDR, 32'h0000_0000);
        rd_check(OFS_FUSE_LO, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0002);
        rd_check(OFS_CTRL, 32'h0000_0000);
        rd_check(OFS_CONFIG, CFG_RESET);
        // Mid-run reset after a preload: registers come back low
        wr(OFS_PRELOAD, 32'h0000_00ff);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd_check(OFS_STATUS, 32'hffff_0000);
        results();
    end
endmodule
